// file: bench/analog_model.sv
`timescale 1ns/1ps
module analog_model (
  // Clock and sampling
  input  wire logic       clk_i,
  input  wire logic       track_i,
  // Levels
  input  wire logic [9:0] vin_i,
  input  wire logic [9:0] trial_i,
  output logic            cmp_o
);
  logic [9:0] held_reg;

  // Hold keeps the level last seen while tracking
  always_ff @(posedge clk_i) begin
    if (track_i) begin
      held_reg <= vin_i;
    end
  end

  assign cmp_o = (held_reg >= trial_i);
endmodule : analog_model

// file: bench/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  fail_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
  logic       clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, rd_d = 0;
  logic [2:0] addr_i = '0;
  logic [7:0] wdata_i = '0, rdata_o, c, exp_b;
  logic [5:0] tmr = '0;
  logic       split = 0, pin = 0, cmp, trk, pwr, dif, irq_o;
  logic [9:0] trial, vin = '0;
  logic [4:0] psel, nsel;
  logic [15:0] e;
  logic [9:0] vals [4];
  logic [2:0] src_tab [6] = '{adc_seq_pkg::SRC_T0, adc_seq_pkg::SRC_T1,
    adc_seq_pkg::SRC_T2, adc_seq_pkg::SRC_T2, adc_seq_pkg::SRC_T3,
    adc_seq_pkg::SRC_T3};
  logic [7:0] exp_q [$];
  int         fail_count = 0;
  int         num_checks = 0;
  int         n;

  sar_adc_sequencer DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .t0_ovf_i(tmr[0]), .t1_ovf_i(tmr[1]), .t2_lo_ovf_i(tmr[2]),
    .t2_hi_ovf_i(tmr[3]), .t2_split_i(split), .t3_lo_ovf_i(tmr[4]),
    .t3_hi_ovf_i(tmr[5]), .t3_split_i(split),
    .external_start_pin_i(pin), .cmp_i(cmp), .trial_o(trial),
    .track_o(trk), .power_o(pwr), .positive_input_select_o(psel),
    .negative_input_select_o(nsel), .diff_mode_o(dif), .irq_o(irq_o)
  );

  analog_model afe (
    .clk_i(clk_i), .track_i(trk), .vin_i(vin), .trial_i(trial),
    .cmp_o(cmp)
  );

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) begin
    if (rd_d) begin
      exp_b = exp_q.pop_front();
      `CHK(rdata_o, exp_b)
    end
  end

  task automatic final_report();
    $display("Done: %0d checks, %0d mismatches", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : rd

  task automatic pulse(input int b);
    @(posedge clk_i);
    tmr[b] <= 1'b1;
    @(posedge clk_i);
    tmr <= '0;
  endtask : pulse

  task automatic wait_irq(input int lim);
    n = 0;
    while (irq_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      final_report();
    end
  endtask : wait_irq

  task automatic idle_quiet();
    repeat (20) @(posedge clk_i);
    #1;
    `CHK(irq_o, 1'b0)
  endtask : idle_quiet

  // Enable first so the hold has tracked before the start
  task automatic conv(input logic [9:0] v, input logic [1:0] m);
    logic [9:0] t;
    t = m[1] ? (v ^ 10'h200) : v;
    e = m[0] ? {t, 6'h00} : (m[1] ? {{6{t[9]}}, t} : {6'h00, t});
    vin <= v;
    wr(3'h3, m[1] ? 8'h05 : 8'h1F);
    wr(3'h0, {7'h40, m[0]});
    wr(3'h0, {7'h48, m[0]});
    wait_irq(40);
    `CHK(n, 12)
    `CHK(dif, m[1])
    `CHK(nsel, m[1] ? 5'h05 : 5'h1F)
    rd(3'h4, e[15:8]);
    rd(3'h5, e[7:0]);
    rd(3'h0, {7'h50, m[0]});
    wr(3'h0, {7'h40, m[0]});
  endtask : conv

  initial begin
    void'($urandom(32'hE5827B17));
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(3'h0, 8'h00);
    rd(3'h1, 8'hF8);
    rd(3'h3, 8'h1F);
    rd(3'h6, 8'h00);
    `CHK(pwr, 1'b0)
    c = 8'($urandom_range(16));
    wr(3'h2, c);
    rd(3'h2, c);
    `CHK(psel, c[4:0])
    $display("test reset and selects done");
    wr(3'h1, 8'h01);
    vals = '{10'h3FF, 10'h000, 10'h200, 10'($urandom)};
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        conv(vals[k], 2'(m));
      end
    end
    wr(3'h4, 8'hAA);
    rd(3'h4, e[15:8]);
    $display("test formats done");
    wr(3'h1, 8'h19);
    wr(3'h0, 8'h90);
    wait_irq(80);
    `CHK(n inside {[44:52]}, 1'b1)
    wr(3'h1, 8'h01);
    wr(3'h0, 8'hC0);
    wr(3'h0, 8'hD0);
    wait_irq(40);
    `CHK(n, 15)
    wr(3'h0, 8'h90);
    repeat (4) @(posedge clk_i);
    wr(3'h0, 8'h00);
    idle_quiet();
    `CHK(pwr, 1'b0)
    rd(3'h0, 8'h00);
    $display("test timing and abort done");
    for (int i = 0; i < 6; i++) begin
      c = {4'h8, src_tab[i], 1'b0};
      split <= ~i[0];
      wr(3'h0, c);
      pulse(i ^ 1);
      idle_quiet();
      pulse(i);
      pulse(i);
      wait_irq(40);
      `CHK(n, 10)
      wr(3'h0, c);
      idle_quiet();
    end
    wr(3'h0, 8'h88);
    pin <= 1'b1;
    wait_irq(40);
    `CHK(irq_o, 1'b1)
    `CHK(n, 16)
    pin <= 1'b0;
    wr(3'h0, 8'hC8);
    repeat (6) @(posedge clk_i);
    #1;
    `CHK(trk, 1'b1)
    @(posedge clk_i);
    pin <= 1'b1;
    wait_irq(40);
    `CHK(n, 16)
    `CHK(trk, 1'b0)
    pin <= 1'b0;
    $display("test start sources done");
    final_report();
  end
endmodule : testbench

// file: hdl/adc_seq_pkg.sv
// Behaviour
// - Converter runs only while enable bit set
// - Input selector offers seventeen selections
// - Ground negative means single-ended, else differential
// - Each conversion loads high and low bytes
// - Control bit 0 picks right/left justify
// - Single-ended: unsigned, unused bits cleared
// - Differential right-justified: sign-extended high byte
// - Differential left-justified: low unused bits cleared
// - Conversion clock is system clock over divider+1
// - Start-mode field selects the trigger source
// - Busy stays high for whole conversion
// - Busy falling edge sets flag, maybe interrupt; here a busy fall from an abort (enable cleared) sets no flag
// - Results valid whenever completion flag reads 1
// - Timer 2/3: low or high byte overflow
// - External pin rising edge starts conversion
// - Low-power tracking adds three clock tracking
// - Low-power external: track while pin low
package adc_seq_pkg;
  localparam int unsigned RES_BITS    = 10;
  localparam int unsigned SEL_BITS    = 5;
  localparam int unsigned DIV_BITS    = 5;
  localparam int unsigned INPUT_SELS  = 17;
  // Register indices on the 3-bit address port
  localparam logic [2:0] ADDR_CTRL    = 3'h0;
  localparam logic [2:0] ADDR_CFG     = 3'h1;
  localparam logic [2:0] ADDR_POS     = 3'h2;
  localparam logic [2:0] ADDR_NEG     = 3'h3;
  localparam logic [2:0] ADDR_RES_HI  = 3'h4;
  localparam logic [2:0] ADDR_RES_LO  = 3'h5;
  // Control register fields
  localparam int unsigned CTRL_LJ     = 0;
  localparam int unsigned CTRL_SRC    = 1;
  localparam int unsigned CTRL_BUSY   = 4;
  localparam int unsigned CTRL_DONE   = 5;
  localparam int unsigned CTRL_LPT    = 6;
  localparam int unsigned CTRL_EN     = 7;
  // Config register fields
  localparam int unsigned CFG_IE      = 0;
  localparam int unsigned CFG_DIV     = 3;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [DIV_BITS-1:0] DIV_RESET = 5'h1F;
  // Start sources
  localparam logic [2:0] SRC_SW       = 3'h0;
  localparam logic [2:0] SRC_T0       = 3'h1;
  localparam logic [2:0] SRC_T2       = 3'h2;
  localparam logic [2:0] SRC_T1       = 3'h3;
  localparam logic [2:0] SRC_EXT      = 3'h4;
  localparam logic [2:0] SRC_T3       = 3'h5;
  localparam logic [SEL_BITS-1:0] NEG_GND = 5'h1F;
  localparam logic [1:0] TRACK_TICKS  = 2'h3;
  localparam logic [5:0] PAD_ZERO     = 6'h00;
  typedef enum logic [1:0] {
    ST_IDLE, ST_TRACK, ST_BITS, ST_FINISH
  } eng_state_e;
endpackage : adc_seq_pkg

// file: hdl/conv_if.sv
`timescale 1ns/1ps
interface conv_if;
  logic       en;
  logic       start;
  logic       lp_track;
  logic       tick;
  logic       cmp;
  logic       busy;
  logic       done;
  logic       tracking;
  logic [9:0] code;
  logic [9:0] trial;
  modport ctrl (
    output en, start, lp_track, tick, cmp,
    input  busy, done, tracking, code, trial
  );
  modport engine (
    input  en, start, lp_track, tick, cmp,
    output busy, done, tracking, code, trial
  );
endinterface : conv_if

// file: hdl/conv_tick_gen.sv
`timescale 1ns/1ps
module conv_tick_gen #(
  parameter int unsigned DIV_W = 5
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Control
  input  wire logic             en_i,
  input  wire logic [DIV_W-1:0] div_i,
  // One pulse per conversion clock period
  output logic                  tick_o
);
  logic [DIV_W-1:0] cnt_reg;
  logic             tick_reg;

  // Period is div_i + 1 system clocks, 0 gives every cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !en_i) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (cnt_reg >= div_i) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  assign tick_o = tick_reg;

  a_tick_gap: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (tick_reg && en_i && div_i != '0 && $stable(div_i)) |=> !tick_reg)
    else $error("conversion clock tick too close");
endmodule : conv_tick_gen

// file: hdl/sar_adc_sequencer.sv
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module sar_adc_sequencer #(
  parameter int unsigned DIV_W = 5
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Register port
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Timer overflow pulses
  input  wire logic       t0_ovf_i,
  input  wire logic       t1_ovf_i,
  input  wire logic       t2_lo_ovf_i,
  input  wire logic       t2_hi_ovf_i,
  input  wire logic       t2_split_i,
  input  wire logic       t3_lo_ovf_i,
  input  wire logic       t3_hi_ovf_i,
  input  wire logic       t3_split_i,
  // External start pin
  input  wire logic       external_start_pin_i,
  // Analog front end
  input  wire logic       cmp_i,
  output logic      [9:0] trial_o,
  output logic            track_o,
  output logic            power_o,
  output logic      [4:0] positive_input_select_o,
  output logic      [4:0] negative_input_select_o,
  output logic            diff_mode_o,
  // Completion
  output logic            irq_o
);
  conv_if cv ();

  // Control register state
  logic       converter_enable_reg;
  logic       low_power_track_select_reg;
  logic       conversion_done_flag_reg;
  logic [2:0] start_source_select_reg;
  logic       left_justify_select_reg;
  logic       irq_enable_reg;
  logic [DIV_W-1:0] conv_clock_divider_reg;
  logic [4:0] pos_sel_reg;
  logic [4:0] neg_sel_reg;
  logic [7:0] result_high_byte_reg;
  logic [7:0] result_low_byte_reg;
  logic [7:0] rdata_reg;
  logic       busy_q_reg;
  logic       track_reg;
  // External pin synchroniser
  logic       ext_s1_reg;
  logic       ext_s2_reg;
  logic       ext_s3_reg;
  logic       ext_lvl_reg;
  logic       ext_rise;
  // Trigger and decode
  logic       wr_ctrl;
  logic       sw_start;
  logic       trig;
  logic       start;
  logic       diff_mode;
  logic       lp_ext;
  logic       busy_fall;
  logic [15:0] formatted;

  conv_tick_gen #(
    .DIV_W (DIV_W)
  ) u_tick (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .en_i   (converter_enable_reg),
    .div_i  (conv_clock_divider_reg),
    .tick_o (cv.tick)
  );

  sar_engine u_eng (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .cv     (cv.engine)
  );

  assign cv.en       = converter_enable_reg;
  assign cv.cmp      = cmp_i;
  assign cv.start    = start;
  assign lp_ext      = start_source_select_reg == adc_seq_pkg::SRC_EXT;
  // Pin edge already marks the end of tracking here
  assign cv.lp_track = low_power_track_select_reg && !lp_ext;

  // Pin passes three flops, change counts when last two agree
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_s3_reg  <= 1'b0;
      ext_lvl_reg <= 1'b0;
    end else begin
      ext_s1_reg <= external_start_pin_i;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      if (ext_s2_reg == ext_s3_reg) ext_lvl_reg <= ext_s3_reg;
    end
  end

  assign ext_rise = (ext_s2_reg == ext_s3_reg) && ext_s3_reg &&
                    !ext_lvl_reg;

  assign wr_ctrl  = wr_i && addr_i == adc_seq_pkg::ADDR_CTRL;
  assign sw_start = wr_ctrl && wdata_i[adc_seq_pkg::CTRL_BUSY] &&
                    start_source_select_reg == adc_seq_pkg::SRC_SW;

  always_comb begin
    case (start_source_select_reg)
      adc_seq_pkg::SRC_SW:  trig = sw_start;
      adc_seq_pkg::SRC_T0:  trig = t0_ovf_i;
      adc_seq_pkg::SRC_T2:  trig = t2_split_i ? t2_lo_ovf_i
                                              : t2_hi_ovf_i;
      adc_seq_pkg::SRC_T1:  trig = t1_ovf_i;
      adc_seq_pkg::SRC_EXT: trig = ext_rise;
      adc_seq_pkg::SRC_T3:  trig = t3_split_i ? t3_lo_ovf_i
                                              : t3_hi_ovf_i;
      default:              trig = 1'b0;
    endcase
  end

  // Running conversion is never restarted
  assign start = converter_enable_reg && trig && !cv.busy;

  assign diff_mode = neg_sel_reg != adc_seq_pkg::NEG_GND;

  // Engine code is offset binary; differential flips the MSB
  function automatic logic [15:0] fmt(
    input logic [9:0] code,
    input logic       diff,
    input logic       lj
  );
    logic [9:0] v;
    v = diff ? {~code[9], code[8:0]} : code;
    if (lj) begin
      fmt = {v, adc_seq_pkg::PAD_ZERO};
    end else if (diff) begin
      fmt = {{6{v[9]}}, v};
    end else begin
      fmt = {adc_seq_pkg::PAD_ZERO, v};
    end
  endfunction : fmt

  assign formatted = fmt(cv.code, diff_mode, left_justify_select_reg);

  // Result pair loads together at conversion end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      result_high_byte_reg <= adc_seq_pkg::RESET_BYTE;
      result_low_byte_reg  <= adc_seq_pkg::RESET_BYTE;
    end else if (cv.done) begin
      result_high_byte_reg <= formatted[15:8];
      result_low_byte_reg  <= formatted[7:0];
    end
  end

  // Busy edge detect for the completion flag
  always_ff @(posedge clk_i) begin
    if (!nrst_i) busy_q_reg <= 1'b0;
    else         busy_q_reg <= cv.busy;
  end

  assign busy_fall = busy_q_reg && !cv.busy;

  // Set wins over a software clear in the same cycle
  // Abort drops busy with no result, so it raises no flag
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      conversion_done_flag_reg <= 1'b0;
    end else if (busy_fall && cv.done) begin
      conversion_done_flag_reg <= 1'b1;
    end else if (wr_ctrl && !wdata_i[adc_seq_pkg::CTRL_DONE]) begin
      conversion_done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      converter_enable_reg       <= 1'b0;
      low_power_track_select_reg <= 1'b0;
      start_source_select_reg    <= adc_seq_pkg::SRC_SW;
      left_justify_select_reg    <= 1'b0;
    end else if (wr_ctrl) begin
      converter_enable_reg       <= wdata_i[adc_seq_pkg::CTRL_EN];
      low_power_track_select_reg <= wdata_i[adc_seq_pkg::CTRL_LPT];
      start_source_select_reg    <=
        wdata_i[adc_seq_pkg::CTRL_SRC +: 3];
      left_justify_select_reg    <= wdata_i[adc_seq_pkg::CTRL_LJ];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      conv_clock_divider_reg <= adc_seq_pkg::DIV_RESET;
      irq_enable_reg         <= 1'b0;
    end else if (wr_i && addr_i == adc_seq_pkg::ADDR_CFG) begin
      conv_clock_divider_reg <=
        wdata_i[adc_seq_pkg::CFG_DIV +: DIV_W];
      irq_enable_reg         <= wdata_i[adc_seq_pkg::CFG_IE];
    end
  end

  // Selections are kept as written; codes past the valid set
  // are left to the analog multiplexer to treat as reserved
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pos_sel_reg <= 5'h00;
      neg_sel_reg <= adc_seq_pkg::NEG_GND;
    end else if (wr_i && addr_i == adc_seq_pkg::ADDR_POS) begin
      pos_sel_reg <= wdata_i[4:0];
    end else if (wr_i && addr_i == adc_seq_pkg::ADDR_NEG) begin
      neg_sel_reg <= wdata_i[4:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !rd_i) begin
      rdata_reg <= adc_seq_pkg::RESET_BYTE;
    end else begin
      case (addr_i)
        adc_seq_pkg::ADDR_CTRL:
          rdata_reg <= {converter_enable_reg,
                        low_power_track_select_reg,
                        conversion_done_flag_reg,
                        cv.busy,
                        start_source_select_reg,
                        left_justify_select_reg};
        adc_seq_pkg::ADDR_CFG:
          rdata_reg <= {conv_clock_divider_reg, 2'h0, irq_enable_reg};
        adc_seq_pkg::ADDR_POS:    rdata_reg <= {3'h0, pos_sel_reg};
        adc_seq_pkg::ADDR_NEG:    rdata_reg <= {3'h0, neg_sel_reg};
        adc_seq_pkg::ADDR_RES_HI: rdata_reg <= result_high_byte_reg;
        adc_seq_pkg::ADDR_RES_LO: rdata_reg <= result_low_byte_reg;
        default:                  rdata_reg <= adc_seq_pkg::RESET_BYTE;
      endcase
    end
  end

  // Continuous tracking unless low-power mode is on
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !converter_enable_reg) begin
      track_reg <= 1'b0;
    end else if (!low_power_track_select_reg) begin
      track_reg <= !cv.busy;
    end else if (lp_ext) begin
      track_reg <= !cv.busy && !ext_lvl_reg;
    end else begin
      track_reg <= cv.tracking;
    end
  end

  assign rdata_o                 = rdata_reg;
  assign trial_o                 = cv.trial;
  assign track_o                 = track_reg;
  assign power_o                 = converter_enable_reg;
  assign positive_input_select_o = pos_sel_reg;
  assign negative_input_select_o = neg_sel_reg;
  assign diff_mode_o             = diff_mode;
  assign irq_o = conversion_done_flag_reg && irq_enable_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_idle_armed;
    converter_enable_reg && !cv.busy;
  endsequence

  sequence s_conv_end;
    busy_q_reg ##0 !cv.busy ##0 cv.done;
  endsequence

  a_off_no_busy: assert property (
    !converter_enable_reg |=> !cv.busy)
    else $error("converter busy while disabled");

  a_sw_start: assert property (
    (s_idle_armed ##0 sw_start) |=> cv.busy [*2])
    else $error("software start did not set busy");

  a_ext_start: assert property (
    (s_idle_armed ##0 lp_ext && ext_rise) |=> cv.busy)
    else $error("external rising edge did not start");

  a_t2_split: assert property (
    (s_idle_armed ##0
     start_source_select_reg == adc_seq_pkg::SRC_T2 &&
     t2_split_i && t2_lo_ovf_i) |=> cv.busy)
    else $error("timer 2 low overflow did not start");

  a_ignore_busy: assert property (
    (cv.busy && trig && !cv.done) |=>
    $stable(result_high_byte_reg) && $stable(result_low_byte_reg))
    else $error("trigger disturbed a running conversion");

  a_flag_on_end: assert property (
    s_conv_end |=> conversion_done_flag_reg)
    else $error("completion flag not set at busy fall");

  a_flag_data: assert property (
    s_conv_end |=> result_low_byte_reg == $past(formatted[7:0]))
    else $error("result not loaded with completion flag");

  a_se_right: assert property (
    (cv.done && !diff_mode && !left_justify_select_reg) |=>
    result_high_byte_reg[7:2] == 6'h00)
    else $error("single-ended upper bits not cleared");

  a_diff_sign: assert property (
    (cv.done && diff_mode && !left_justify_select_reg) |=>
    result_high_byte_reg[7:2] == {6{result_high_byte_reg[1]}})
    else $error("differential sign extension wrong");

  a_left_low: assert property (
    (cv.done && left_justify_select_reg) |=>
    result_low_byte_reg[5:0] == 6'h00)
    else $error("left-justified low bits not cleared");

  a_busy_span: assert property (
    (s_idle_armed ##0 start && !cv.lp_track &&
     conv_clock_divider_reg == '0 && !wr_i) |=>
    cv.busy [*8] ##1 cv.busy [*3] ##1 !cv.busy)
    else $error("conversion length wrong at divide by one");

  sequence s_lp_ext_mode;
    converter_enable_reg && low_power_track_select_reg && lp_ext;
  endsequence

  a_res_high: assert property (
    cv.done |=> result_high_byte_reg == $past(formatted[15:8]))
    else $error("result high byte not loaded at conversion end");

  // Only an abort may drop busy without a completion pulse
  a_busy_end: assert property (
    ($fell(cv.busy) && $past(converter_enable_reg)) |-> cv.done)
    else $error("busy fell before the conversion completed");

  a_off_dark: assert property (
    !converter_enable_reg |=> !track_reg && !cv.tracking)
    else $error("tracking while converter disabled");

  a_ext_hold: assert property (
    (s_lp_ext_mode ##0 ext_lvl_reg) |=> !track_reg)
    else $error("tracking while start pin high");

  a_ext_track: assert property (
    (s_lp_ext_mode ##0 !ext_lvl_reg && !cv.busy) |=> track_reg)
    else $error("not tracking while start pin low");
endmodule : sar_adc_sequencer

// file: hdl/sar_engine.sv
`timescale 1ns/1ps
module sar_engine (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Control and status
  conv_if.engine    cv
);
  adc_seq_pkg::eng_state_e st_reg;
  logic [1:0] trk_reg;
  logic [9:0] sar_reg;
  logic [9:0] mask_reg;
  logic [9:0] code_reg;
  logic       done_reg;
  logic       enter_bits;

  assign enter_bits = (st_reg == adc_seq_pkg::ST_IDLE && cv.start &&
                       !cv.lp_track) ||
                      (st_reg == adc_seq_pkg::ST_TRACK && cv.tick &&
                       trk_reg == adc_seq_pkg::TRACK_TICKS - 2'h1);

  // Track, ten bit trials, one load period
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !cv.en) begin
      st_reg <= adc_seq_pkg::ST_IDLE;
    end else begin
      case (st_reg)
        adc_seq_pkg::ST_IDLE: begin
          if (cv.start && cv.lp_track) st_reg <= adc_seq_pkg::ST_TRACK;
          else if (cv.start) st_reg <= adc_seq_pkg::ST_BITS;
        end
        adc_seq_pkg::ST_TRACK: begin
          if (enter_bits) st_reg <= adc_seq_pkg::ST_BITS;
        end
        adc_seq_pkg::ST_BITS: begin
          if (cv.tick && mask_reg[0]) st_reg <= adc_seq_pkg::ST_FINISH;
        end
        adc_seq_pkg::ST_FINISH: begin
          if (cv.tick) st_reg <= adc_seq_pkg::ST_IDLE;
        end
        default: st_reg <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || st_reg != adc_seq_pkg::ST_TRACK) begin
      trk_reg <= 2'h0;
    end else if (cv.tick) begin
      trk_reg <= trk_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sar_reg  <= 10'h000;
      mask_reg <= 10'h000;
    end else if (enter_bits) begin
      sar_reg  <= 10'h200;
      mask_reg <= 10'h200;
    end else if (st_reg == adc_seq_pkg::ST_BITS && cv.tick) begin
      sar_reg  <= (cv.cmp ? sar_reg : (sar_reg & ~mask_reg)) |
                  (mask_reg >> 1);
      mask_reg <= mask_reg >> 1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      done_reg <= 1'b0;
      code_reg <= 10'h000;
    end else begin
      done_reg <= cv.en && cv.tick &&
                  st_reg == adc_seq_pkg::ST_FINISH;
      if (cv.tick && st_reg == adc_seq_pkg::ST_FINISH) begin
        code_reg <= sar_reg;
      end
    end
  end

  assign cv.busy     = st_reg != adc_seq_pkg::ST_IDLE;
  assign cv.done     = done_reg;
  assign cv.code     = code_reg;
  assign cv.trial    = sar_reg;
  assign cv.tracking = st_reg == adc_seq_pkg::ST_TRACK;

  a_lp_track: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (cv.en && cv.start && cv.lp_track && !cv.busy) |=> cv.tracking)
    else $error("low-power start did not enter tracking");
endmodule : sar_engine
